/* File: logic/sof_monitor.sv */
`timescale 1ns/1ps
// Operation
// - Both channels on while logical input is one, off while zero.
// - With restart gating, hold outputs off after a fall until reset.
// - Manual reset type accepts one rising edge of reset input.
// - Monitored reset type needs rise then fall of reset input.
// - Status option exposes current output state to other logic.
// - Timed mode: feedback must go low within window, else fault.
// - Untimed mode: feedback checked high at power-on and in operation.
// - Untimed mode: feedback must return high within 10 s of off.
// - Untimed feedback fault is latched, flashed, cleared by power cycle.
// - Error output, when enabled, goes high on feedback error.
// - Error output holds until power cycle or global reset.
// - One restart and feedback input per output channel pair.
// - Split block offers single or double channel output types.
// - Split restart input present only with gating or timing enabled.
// - No-test-pulse option stops dip test, flags reduced integrity.
module sof_monitor
    import sof_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic [3:0]          regAddr,
    input  wire logic [31:0]         regWdata,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output logic      [31:0]         regRdata,
    input  wire logic [NUM_CH-1:0]   logicIn,
    input  wire logic [NUM_PAIR-1:0] restartFeedbackInput,
    input  wire logic [NUM_PAIR-1:0] contactorFeedback,
    input  wire logic                globalResetOperator,
    output logic [NUM_CH-1:0]        safetySwitchingOutput,
    output logic [NUM_CH-1:0]        statusTap,
    output logic [NUM_PAIR-1:0]      errorOutput,
    output logic [NUM_PAIR-1:0]      perOutputFaultIndicator,
    output logic [NUM_PAIR-1:0]      reducedIntegrity,
    output logic                     irq
);

    ////////////////////////////////////////////////////////////////////////
    // Configuration and interrupt registers.
    sof_cfg_t [NUM_PAIR-1:0]           cfg_reg;
    logic [NUM_PAIR-1:0][MS_CNT_W-1:0] win_reg;
    logic [NUM_PAIR-1:0]               irqStat_reg;
    logic [NUM_PAIR-1:0]               irqMask_reg;
    logic                              swReset_reg;
    logic                              powerUp_reg;
    logic [PRE_CNT_W-1:0]              pre_reg;
    logic                              msTick;
    logic [MS_CNT_W-1:0]               dipMs_reg;
    logic [MS_CNT_W-1:0]               blinkMs_reg;
    logic                              blink_reg;
    logic [7:0]                        dipLen_reg;
    logic                              dip;
    logic [NUM_PAIR-1:0]               pairOn;
    logic [NUM_CH-1:0]                 chOn;
    logic [NUM_PAIR-1:0]               fbkErr;
    logic [NUM_PAIR-1:0]               errOut;
    logic [NUM_PAIR-1:0]               errEvent;
    logic                              gReset;

    assign gReset = globalResetOperator | swReset_reg;

    // Register writes; cfg and window are held per pair.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_reg     <= {NUM_PAIR{CTRL_RST}};
            win_reg     <= {NUM_PAIR{WIN_RST}};
            irqMask_reg <= '0;
            swReset_reg <= 1'b0;
        end else begin
            swReset_reg <= regWr && regAddr == ADDR_GRESET && regWdata[0];
            if (regWr) begin
                unique case (regAddr)
                    ADDR_CTRL0:   cfg_reg[0] <= sof_cfg_t'(regWdata[CTRL_W-1:0]);
                    ADDR_CTRL1:   cfg_reg[1] <= sof_cfg_t'(regWdata[CTRL_W-1:0]);
                    ADDR_WIN0:    win_reg[0] <= regWdata[MS_CNT_W-1:0];
                    ADDR_WIN1:    win_reg[1] <= regWdata[MS_CNT_W-1:0];
                    ADDR_IRQMASK: irqMask_reg <= regWdata[NUM_PAIR-1:0];
                    default:      ;
                endcase
            end
        end
    end

    // Sticky events; a new event wins over a write-one clear.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irqStat_reg <= '0;
        end else begin
            irqStat_reg <= (irqStat_reg &
                ~((regWr && regAddr == ADDR_IRQSTAT) ?
                  regWdata[NUM_PAIR-1:0] : '0)) | errEvent;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) irq <= 1'b0;
        else         irq <= |(irqStat_reg & irqMask_reg);
    end

    // Read data, one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdata <= '0;
        end else if (regRd) begin
            unique case (regAddr)
                ADDR_CTRL0:   regRdata <= 32'(cfg_reg[0]);
                ADDR_CTRL1:   regRdata <= 32'(cfg_reg[1]);
                ADDR_WIN0:    regRdata <= 32'(win_reg[0]);
                ADDR_WIN1:    regRdata <= 32'(win_reg[1]);
                ADDR_STATUS:  regRdata <= 32'({errOut, fbkErr, chOn});
                ADDR_IRQSTAT: regRdata <= 32'(irqStat_reg);
                ADDR_IRQMASK: regRdata <= 32'(irqMask_reg);
                default:      regRdata <= '0;
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Millisecond tick divider and power-on flag.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_reg     <= '0;
            msTick      <= 1'b0;
            powerUp_reg <= 1'b1;
        end else begin
            powerUp_reg <= 1'b0;
            msTick      <= pre_reg == PRE_CNT_W'(MS_CYCLES - 1);
            if (pre_reg == PRE_CNT_W'(MS_CYCLES - 1)) pre_reg <= '0;
            else pre_reg <= pre_reg + 1'b1;
        end
    end

    // Dip test and fault blink timing; short dips stay within response time.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dipMs_reg   <= '0;
            blinkMs_reg <= '0;
            blink_reg   <= 1'b0;
            dipLen_reg  <= '0;
        end else begin
            if (msTick) begin
                if (dipMs_reg == MS_CNT_W'(DIP_PERIOD_MS - 1)) begin
                    dipMs_reg  <= '0;
                    dipLen_reg <= 8'(DIP_LEN_CYCLES);
                end else begin
                    dipMs_reg <= dipMs_reg + 1'b1;
                end
                if (blinkMs_reg == MS_CNT_W'(BLINK_MS - 1)) begin
                    blinkMs_reg <= '0;
                    blink_reg   <= ~blink_reg;
                end else begin
                    blinkMs_reg <= blinkMs_reg + 1'b1;
                end
            end else if (dipLen_reg != '0) begin
                dipLen_reg <= dipLen_reg - 1'b1;
            end
        end
    end
    assign dip = dipLen_reg != '0;

    ////////////////////////////////////////////////////////////////////////
    // one input per pair
    genvar p;
    generate
        for (p = 0; p < NUM_PAIR; p++) begin : g_pair
            logic rstIn;
            logic pairIn;
            assign rstIn = (cfg_reg[p].splitSingle &&
                            !sof_rstin_present(cfg_reg[p])) ?
                           1'b0 : restartFeedbackInput[p];
            // Split channels share one restart gate, so it re-arms only
            // once both of their inputs are low.
            // single or double
            assign pairIn = cfg_reg[p].splitSingle ?
                            (logicIn[2*p] | logicIn[2*p+1]) : logicIn[2*p];
            sof_pair_ctrl u_pair (
                .clk       (clk),
                .arst_n    (arst_n),
                .msTick    (msTick),
                .gReset    (gReset),
                .cfg       (cfg_reg[p]),
                .winMs     (win_reg[p]),
                .logicIn   (pairIn),
                .restartIn (rstIn),
                .fbkIn     (contactorFeedback[p]),
                .powerUp   (powerUp_reg),
                .outOn     (pairOn[p]),
                .fbkErr    (fbkErr[p]),
                .errOut    (errOut[p]),
                .errEvent  (errEvent[p])
            );
            assign chOn[2*p]   = cfg_reg[p].splitSingle ?
                                 (pairOn[p] & logicIn[2*p]) : pairOn[p];
            assign chOn[2*p+1] = cfg_reg[p].splitSingle ?
                                 (pairOn[p] & logicIn[2*p+1]) : pairOn[p];

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    safetySwitchingOutput[2*p+1:2*p] <= '0;
                    reducedIntegrity[p]              <= 1'b0;
                end else begin
                    safetySwitchingOutput[2*p+1:2*p] <=
                        chOn[2*p+1:2*p] &
                        {2{!dip || cfg_reg[p].noTestPulse}};
                    reducedIntegrity[p] <= cfg_reg[p].noTestPulse;
                end
            end

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    statusTap[2*p+1:2*p]       <= '0;
                    perOutputFaultIndicator[p] <= 1'b0;
                    errorOutput[p]             <= 1'b0;
                end else begin
                    statusTap[2*p+1:2*p] <= chOn[2*p+1:2*p] &
                                            {2{cfg_reg[p].statusEnable}};
                    // Lit while blink_reg is low; the blink runs free, so a fresh fault may wait up to 250 ms.
                    perOutputFaultIndicator[p] <= fbkErr[p] & !blink_reg;
                    errorOutput[p] <= errOut[p];
                end
            end
        end
    endgenerate

endmodule // sof_monitor

/* File: logic/sof_pair_ctrl.sv */
`timescale 1ns/1ps
module sof_pair_ctrl
    import sof_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic                msTick,
    input  wire logic                gReset,
    input  wire sof_cfg_t            cfg,
    input  wire logic [MS_CNT_W-1:0] winMs,
    input  wire logic                logicIn,
    input  wire logic                restartIn,
    input  wire logic                fbkIn,
    input  wire logic                powerUp,
    output logic                     outOn,
    output logic                     fbkErr,
    output logic                     errOut,
    output logic                     errEvent
);

    sof_rst_t            rst_reg;
    logic                inPrev_reg;
    logic                rstPrev_reg;
    logic                outPrev_reg;
    logic [MS_CNT_W-1:0] ms_reg;
    logic                inFall;
    logic                rstRise;
    logic                rstFall;
    logic                ok;
    logic                timeErr;
    logic                offErr;
    logic                pwrErr;
    logic                newErr;

    assign inFall  = inPrev_reg & ~logicIn;
    assign rstRise = ~rstPrev_reg & restartIn;
    assign rstFall = rstPrev_reg & ~restartIn;

    ////////////////////////////////////////////////////////////////////////
    // Edge history of the input, reset button and output.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            inPrev_reg  <= 1'b0;
            rstPrev_reg <= 1'b0;
            outPrev_reg <= 1'b0;
        end else begin
            inPrev_reg  <= logicIn;
            rstPrev_reg <= restartIn;
            outPrev_reg <= outOn;
        end
    end

    // Restart gate: wait after each fall until a valid reset event.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_reg <= RS_WAIT;
        end else if (!cfg.restartGate) begin
            rst_reg <= RS_RUN;
        end else begin
            unique case (rst_reg)
                RS_RUN: begin
                    if (inFall || !logicIn) rst_reg <= RS_WAIT;
                end
                RS_WAIT: begin
                    if (rstRise && !cfg.monitoredReset) rst_reg <= RS_RUN;
                    else if (rstRise) rst_reg <= RS_PRESSED;
                end
                RS_PRESSED: begin
                    if (rstFall) rst_reg <= RS_RUN;
                end
                default: rst_reg <= RS_WAIT;
            endcase
        end
    end

    assign ok = logicIn && !fbkErr && (rst_reg == RS_RUN || !cfg.restartGate);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) outOn <= 1'b0;
        else         outOn <= ok;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ms_reg <= '0;
        end else if (outOn != outPrev_reg) begin
            ms_reg <= '0;
        end else if (msTick && ms_reg != '1) begin
            ms_reg <= ms_reg + 1'b1;
        end
    end

    // Both judges skip the switching cycle, where the count is still stale.
    // feedback must drop
    assign timeErr = cfg.timeMonitor && outOn && outPrev_reg && fbkIn &&
                     ms_reg >= winMs;
    assign offErr = !cfg.timeMonitor && !outOn && !outPrev_reg && !fbkIn &&
                    ms_reg >= MS_CNT_W'(OFF_FBK_TIME_MS);
    assign pwrErr = !cfg.timeMonitor && powerUp && !fbkIn;
    // A feedback left open by design is never judged.
    assign newErr = !cfg.fbkUnconnected && (timeErr || offErr || pwrErr);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fbkErr   <= 1'b0;
            errEvent <= 1'b0;
        end else begin
            errEvent <= newErr && !fbkErr;
            if (newErr) fbkErr <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)                      errOut <= 1'b0;
        else if (newErr && cfg.errOutEnable) errOut <= 1'b1;
        else if (gReset)                  errOut <= 1'b0;
    end

endmodule // sof_pair_ctrl

/* File: logic/sof_pkg.sv */
package sof_pkg;

    // Clock and timing figures.
    localparam int CLK_HZ          = 25_000_000;
    localparam int MS_PER_S        = 1000;
    localparam int MS_CYCLES       = CLK_HZ / MS_PER_S;
    localparam int OFF_FBK_TIME_S  = 10;
    localparam int OFF_FBK_TIME_MS = OFF_FBK_TIME_S * MS_PER_S;
    localparam int MS_CNT_W        = 16;
    localparam int PRE_CNT_W       = 15;
    localparam int DIP_PERIOD_MS   = 500;
    localparam int DIP_LEN_CYCLES  = 10;
    localparam int NUM_CH          = 4;
    localparam int NUM_PAIR        = NUM_CH / 2;
    localparam int BLINK_MS        = 250;

    // Register map of the plain port.
    localparam logic [3:0] ADDR_CTRL0   = 4'h0;
    localparam logic [3:0] ADDR_CTRL1   = 4'h1;
    localparam logic [3:0] ADDR_WIN0    = 4'h2;
    localparam logic [3:0] ADDR_WIN1    = 4'h3;
    localparam logic [3:0] ADDR_STATUS  = 4'h4;
    localparam logic [3:0] ADDR_IRQSTAT = 4'h5;
    localparam logic [3:0] ADDR_IRQMASK = 4'h6;
    localparam logic [3:0] ADDR_GRESET  = 4'h7;

    // Control field positions inside a pair control register.
    localparam int CB_RESTART  = 0;
    localparam int CB_MONITOR  = 1;
    localparam int CB_TIMEMON  = 2;
    localparam int CB_ERROUT   = 3;
    localparam int CB_STATUS   = 4;
    localparam int CB_NOTEST   = 5;
    localparam int CB_SPLIT    = 6;
    localparam int CB_FBKNC    = 7;
    localparam int CTRL_W      = 8;

    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [15:0] WIN_RST  = 16'h0064;

    // Pair configuration carried as a struct.
    typedef struct packed {
        logic fbkUnconnected;
        logic splitSingle;
        logic noTestPulse;
        logic statusEnable;
        logic errOutEnable;
        logic timeMonitor;
        logic monitoredReset;
        logic restartGate;
    } sof_cfg_t;

    // Restart gate states, Gray along idle->armed->pressed.
    typedef enum logic [1:0] {
        RS_RUN     = 2'b00,
        RS_WAIT    = 2'b01,
        RS_PRESSED = 2'b11
    } sof_rst_t;

    // Decoded pair activity used by the restart input presence.
    function automatic logic sof_rstin_present(input sof_cfg_t c);
        return c.restartGate | c.timeMonitor;
    endfunction

endpackage

/* File: tb/sof_contactor_model.sv */
`timescale 1ns/1ps
module sof_contactor_model
    import sof_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic [NUM_CH-1:0]   coil,
    input  wire logic [NUM_PAIR-1:0] stuck,
    input  wire logic                slow,
    output logic      [NUM_PAIR-1:0] contactor_feedback
);
    ////////////////////////////////////////////////
    logic [NUM_PAIR-1:0][4:0] lag;

    // The closed contacts open a few cycles after the coil pulls in and
    // close again after release; a stuck pair never pulls in at all.
    // contacts in series
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            contactor_feedback <= '1;
            lag <= '0;
        end else begin
            for (int p = 0; p < NUM_PAIR; p++) begin
                if ((coil[2*p] & ~stuck[p]) != contactor_feedback[p]) begin
                    lag[p] <= 5'h0;
                end else if (lag[p] < (slow ? 5'h14 : 5'h1)) begin
                    lag[p] <= lag[p] + 5'h1;
                end else begin
                    contactor_feedback[p] <= ~contactor_feedback[p];
                    lag[p] <= 5'h0;
                end
            end
        end
    end
endmodule // sof_contactor_model

/* File: tb/sof_monitor_asserts.sv */
`timescale 1ns/1ps
module sof_monitor_asserts
    import sof_pkg::*;
(
    input wire logic                clk,
    input wire logic                arst_n,
    input wire logic [3:0]          regAddr,
    input wire logic [31:0]         regWdata,
    input wire logic                regWr,
    input wire logic                regRd,
    input wire logic [31:0]         regRdata,
    input wire logic [NUM_CH-1:0]   logicIn,
    input wire logic                globalResetOperator,
    input wire logic [NUM_CH-1:0]   safetySwitchingOutput,
    input wire logic [NUM_PAIR-1:0] errorOutput,
    input wire logic [NUM_PAIR-1:0] reducedIntegrity,
    input wire logic                irq
);
    ////////////////////////////////////////////////
    // One clock domain, so clock and reset are stated once.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // Both ways of clearing the error output, pin or register.
    logic gClr;
    assign gClr = globalResetOperator
                | (regWr && regAddr == ADDR_GRESET && regWdata[0]);

    // A pair 0 fault appearing, then the span after it has settled.
    sequence s_errRise;
        $rose(errorOutput[0]);
    endsequence
    sequence s_errSettled;
        s_errRise ##3 1'h1;
    endsequence

    ////////////////////////////////////////////////
    property p_offFollow;
        !logicIn[0] |-> ##2 !safetySwitchingOutput[0];
    endproperty
    a_offFollow: assert property (p_offFollow)
        else $error("channel 0 on two cycles after input low");
    property p_riseCause;
        $rose(safetySwitchingOutput[0]) |-> $past(logicIn[0], 2);
    endproperty
    a_riseCause: assert property (p_riseCause)
        else $error("channel 0 rose without input high");
    property p_errOff;
        s_errRise |-> ##[0:2] !safetySwitchingOutput[0];
    endproperty
    a_errOff: assert property (p_errOff)
        else $error("channel 0 not forced off on fault");
    // The latched fault keeps the whole pair off.
    property p_errHold;
        s_errSettled |-> (safetySwitchingOutput[1:0] == 2'h0) [*8];
    endproperty
    a_errHold: assert property (p_errHold)
        else $error("pair 0 came back on while faulted");
    // The register clear passes one more flop, hence three cycles back.
    property p_errSticky;
        $fell(errorOutput[0]) |->
            $past(gClr) || $past(gClr, 2) || $past(gClr, 3);
    endproperty
    a_errSticky: assert property (p_errSticky)
        else $error("error output dropped without a clear");
    property p_rdIdle;
        !$past(regRd) |-> regRdata == 32'h0;
    endproperty
    a_rdIdle: assert property (p_rdIdle)
        else $error("read data not zero outside a read");
    property p_maskOff;
        regWr && regAddr == ADDR_IRQMASK && regWdata[1:0] == 2'h0
            |-> ##[1:3] !irq;
    endproperty
    a_maskOff: assert property (p_maskOff)
        else $error("interrupt high with all sources masked");
    property p_noTest;
        regWr && regAddr == ADDR_CTRL0 && regWdata[CB_NOTEST]
            |-> ##[1:3] reducedIntegrity[0];
    endproperty
    a_noTest: assert property (p_noTest)
        else $error("reduced integrity flag not raised");
endmodule // sof_monitor_asserts

/* File: tb/sof_monitor_tb.sv */
`timescale 1ns/1ps
module sof_monitor_tb
    import sof_pkg::*;
;
    logic        clk, arst_n, regWr, regRd, globalResetOperator, slow, irq;
    logic [3:0]  regAddr, logicIn, out, statusTap;
    logic [31:0] regWdata, regRdata, seed, v;
    logic [1:0]  rstBtn, contactor_feedback, errorOutput, faultInd, redInt, stuck;
    int          failures, n_compared;

    sof_monitor sof_monitor_i (
        .clk, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .logicIn, .restartFeedbackInput(rstBtn), .contactorFeedback(contactor_feedback),
        .globalResetOperator, .safetySwitchingOutput(out), .statusTap,
        .errorOutput, .perOutputFaultIndicator(faultInd),
        .reducedIntegrity(redInt), .irq
    );
    sof_contactor_model sof_contactor_model_i (
        .clk, .arst_n, .coil(out), .stuck, .slow, .contactor_feedback
    );

    ////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One bus access; a read compares the word that stands one cycle on.
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        regWr <= w;
        regRd <= !w;
        regAddr <= a;
        regWdata <= w ? d : 32'h0;
        @(posedge clk);
        regWr <= 1'h0;
        regRd <= 1'h0;
        #1;
        if (!w) chk(regRdata, d);
    endtask

    // Drive the pins, then allow the two-stage output path to settle.
    task automatic step(input logic [3:0] li, input logic [1:0] rb,
                        input logic g = 1'h0);
        @(posedge clk);
        logicIn <= li;
        rstBtn <= rb;
        globalResetOperator <= g;
        repeat (4) @(posedge clk);
        #1;
    endtask

    // Wait for the pair 0 error output, a little over one millisecond.
    task automatic wait_err();
        for (int i = 0; i < 30000 && errorOutput[0] !== 1'h1; i++) begin
            @(posedge clk);
        end
        #1;
    endtask

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic give_verdict();
        $display("TB: %0d compared, %0d failed", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////
    // Clock and a watchdog sized well past the longest fault wait.
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        give_verdict();
    end

    initial begin
        seed = 32'h8592F2CC;
        {failures, n_compared} = '0;
        {arst_n, regWr, regRd, globalResetOperator, slow} = '0;
        {regAddr, logicIn, regWdata, rstBtn, stuck} = '0;
        repeat (2) @(posedge clk);
        arst_n <= 1'h1;
        // Power-on values and an unmapped word.
        acc(1'h0, ADDR_CTRL0, {24'h0, CTRL_RST});
        acc(1'h0, ADDR_WIN0, {16'h0, WIN_RST});
        acc(1'h0, ADDR_STATUS, 32'h0);
        acc(1'h0, 4'hA, 32'h0);
        $display("TB: reset test done");
        // Random levels on pair 0; pair 1 ignores its odd input bit.
        acc(1'h1, ADDR_CTRL0, (32'h1 << CB_STATUS) | (32'h1 << CB_NOTEST));
        for (int i = 0; i < 24; i++) begin
            v = xs();
            slow <= v[1];
            step({v[2], 2'h0, v[0]}, 2'h0);
            chk(out[1:0], {2{v[0]}});
            chk(statusTap[1:0], {2{v[0]}});
            chk(out[3:2], 2'h0);
        end
        chk(redInt[0], 1'h1);
        $display("TB: follow test done");
        // Restart gating on pair 1, manual then monitored.
        for (int m = 0; m < 2; m++) begin
            acc(1'h1, ADDR_CTRL1, m ? 32'h3 : 32'h1);
            step(4'h4, 2'h0);
            step(4'h0, 2'h0);
            step(4'h4, 2'h0);
            chk(out[3:2], 2'h0);
            step(4'h4, 2'h2);
            chk(out[3:2], m ? 2'h0 : 2'h3);
            step(4'h4, 2'h0);
            chk(out[3:2], 2'h3);
            step(4'h0, 2'h0);
            chk(out[3:2], 2'h0);
            step(4'h4, 2'h0);
            chk(out[3:2], 2'h0);
            step(4'h0, 2'h0);
        end
        // Split pair 1: each single channel follows its own input.
        acc(1'h1, ADDR_CTRL1, 32'h1 << CB_SPLIT);
        step(4'h4, 2'h0);
        chk(out[3:2], 2'h1);
        step(4'h8, 2'h0);
        chk(out[3:2], 2'h2);
        step(4'h0, 2'h0);
        $display("TB: restart test done");
        // Timed feedback with a 1 ms window: slow but healthy, then stuck.
        acc(1'h1, ADDR_WIN0, 32'h1);
        acc(1'h1, ADDR_CTRL0, (32'h1 << CB_TIMEMON) | (32'h1 << CB_ERROUT));
        acc(1'h1, ADDR_IRQMASK, 32'h0);
        slow <= 1'h1;
        step(4'h1, 2'h0);
        repeat (30000) @(posedge clk);
        #1;
        chk(out[1:0], 2'h3);
        chk(errorOutput, 2'h0);
        step(4'h0, 2'h0);
        stuck <= 2'h1;
        step(4'h1, 2'h0);
        wait_err();
        chk(errorOutput, 2'h1);
        chk(out[1:0], 2'h0);
        chk(irq, 1'h0);
        chk(faultInd, 2'h1);
        acc(1'h0, ADDR_STATUS, 32'h50);
        acc(1'h1, ADDR_IRQMASK, 32'h1);
        step(4'h1, 2'h0);
        chk(irq, 1'h1);
        acc(1'h1, ADDR_IRQSTAT, 32'h1);
        step(4'h1, 2'h0);
        chk(irq, 1'h0);
        // The operator clears the error output but not the latched fault.
        step(4'h1, 2'h0, 1'h1);
        step(4'h1, 2'h0);
        chk(errorOutput, 2'h0);
        chk(out[1:0], 2'h0);
        acc(1'h0, ADDR_STATUS, 32'h10);
        $display("TB: feedback test done");
        // Only a power cycle frees the latch; pair 1 feedback is left open.
        @(posedge clk);
        arst_n <= 1'h0;
        logicIn <= 4'h0;
        stuck <= 2'h3;
        repeat (2) @(posedge clk);
        arst_n <= 1'h1;
        acc(1'h0, ADDR_STATUS, 32'h0);
        acc(1'h1, ADDR_WIN0, 32'h1);
        acc(1'h1, ADDR_CTRL0, (32'h1 << CB_TIMEMON) | (32'h1 << CB_ERROUT));
        acc(1'h1, ADDR_CTRL1, (32'h1 << CB_TIMEMON) | (32'h1 << CB_ERROUT)
                              | (32'h1 << CB_FBKNC));
        step(4'h5, 2'h0);
        wait_err();
        chk(errorOutput, 2'h1);
        chk(out[3:2], 2'h3);
        acc(1'h1, ADDR_GRESET, 32'h1);
        step(4'h5, 2'h0);
        chk(errorOutput, 2'h0);
        $display("TB: power cycle test done");
        give_verdict();
    end
endmodule // sof_monitor_tb

bind sof_monitor sof_monitor_asserts sof_monitor_asserts_i (
    .clk, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .logicIn, .globalResetOperator, .safetySwitchingOutput,
    .errorOutput, .reducedIntegrity, .irq
);
